// ### common/tcad_pkg.sv
// Package: constants, types and timing for the Type-C attach detector
package tcad_pkg;

	// Line classification codes
	typedef enum logic [1:0] {
		LN_OPEN = 2'h0,
		LN_RA   = 2'h1,
		LN_RD   = 2'h2
	} tcad_line_t;

	// Port role
	typedef enum logic [1:0] {
		ROLE_SOURCE = 2'h0,
		ROLE_SINK   = 2'h1,
		ROLE_DRP    = 2'h2
	} tcad_role_t;

	// Pull-up current level
	typedef enum logic [1:0] {
		RP_DEFAULT = 2'h0,
		RP_MEDIUM  = 2'h1,
		RP_HIGH    = 2'h2
	} tcad_rp_t;

	// Connection state
	typedef enum logic [3:0] {
		ST_NONE       = 4'h0,
		ST_SINK_A     = 4'h1,
		ST_SINK_B     = 4'h2,
		ST_CABLE_A    = 4'h3,
		ST_CABLE_B    = 4'h4,
		ST_CBL_SINK_A = 4'h5,
		ST_CBL_SINK_B = 4'h6,
		ST_DEBUG_ACC  = 4'h7,
		ST_AUDIO_ACC  = 4'h8,
		ST_SNK_ATT    = 4'h9
	} tcad_state_t;

	// Comparator results for one line, per pull-up level
	typedef struct packed {
		logic below_ra;    // Voltage under the Ra/Rd boundary
		logic below_open;  // Voltage under the default-level open threshold
		logic above_disc;  // Above disconnect threshold for active level
		logic adv_medium;  // Sink view: at least medium advertisement
		logic adv_high;    // Sink view: high advertisement
	} tcad_cmp_t;

	// Termination applied to one line
	typedef struct packed {
		logic     pullup_en;
		tcad_rp_t pullup_lvl;
		logic     pulldown_en;
	} tcad_term_t;

	// Timing
	localparam int CLK_MHZ           = 250;
	localparam int DEBOUNCE_US       = 150;
	localparam int DEBOUNCE_CYC      = DEBOUNCE_US * CLK_MHZ;
	localparam int DRP_HALF_US       = 35000;
	localparam int DRP_HALF_CYC      = DRP_HALF_US * CLK_MHZ;
	localparam int FSD_NS            = 8;
	localparam int FSD_CYC           = (FSD_NS * CLK_MHZ) / 1000;

endpackage : tcad_pkg

// ### src/tcad_attach_detect.sv
// Module: Type-C configuration line attach, orientation and protection logic
// What this block does
// R1: Source, both open: watch both lines, VBUS and VCONN off.
// R2: Source, line A Rd, B open: VBUS on, no VCONN, watch A.
// R3: Source, line B Rd, A open: VBUS on, no VCONN, watch B.
// R4: Source, A Ra, B open: cable only, watch both, power off.
// R5: Source, B Ra, A open: cable only, watch both, power off.
// R6: Source, A Ra, B Rd: VBUS on, VCONN on A, watch B.
// R7: Source, A Rd, B Ra: VBUS on, VCONN on B, watch A.
// R8: Both Rd reports debug, both Ra audio; either line detaches.
// R9: Default pull-up until VBUS switch closes; then firmware level.
// R10: Disconnect when monitored line stays above threshold for debounce.
// R11: Ra pulldown classifies as active cable VCONN input, not Rd.
// R12: Sink: pulldowns on both, attach on VBUS, decode advertisement.
// R13: Dual role: alternate lines between pulldown and pull-up.
// R14: Dead battery presents Rd; removed once VBUS power unneeded.
// R15: Overvoltage or reverse current opens cable switch, stops transmitter.
// R16: Comparator outputs encode each line as open, Ra or Rd.
module tcad_attach_detect
	import tcad_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
	parameter int DRP_HALF_CYCLES = DRP_HALF_CYC
) (
	input  wire logic       MCLK,
	input  wire logic       RESETN,
	input  wire tcad_role_t ROLE,
	input  wire tcad_rp_t   RP_LEVEL_REQ,
	input  wire logic       DEAD_BATTERY,
	input  wire logic       VBUS_PRESENT,
	input  wire logic       VBUS_SWITCH_CLOSED,
	input  wire logic       LINE_OVERVOLTAGE,
	input  wire logic       SUPPLY_REVERSE_CURRENT,
	input  wire tcad_cmp_t  CMP_LINE_A,
	input  wire tcad_cmp_t  CMP_LINE_B,
	output tcad_term_t      TERM_LINE_A,
	output tcad_term_t      TERM_LINE_B,
	output tcad_state_t     CONN_STATE,
	output logic            VBUS_EN,
	output logic            VCONN_A_EN,
	output logic            VCONN_B_EN,
	output logic            WATCH_A,
	output logic            WATCH_B,
	output logic            FLIPPED,
	output tcad_rp_t        ADV_CURRENT,
	output logic            CABLE_SWITCH_EN,
	output logic            PD_TX_DISABLE,
	output logic            FAULT
);

	if (DEBOUNCE_CYCLES < 1 || DRP_HALF_CYCLES < 1) begin : g_bad_timing
		$error("Timing counts must be at least one cycle");
	end

	// Line classification
	function automatic tcad_line_t classify(input tcad_cmp_t c);
		tcad_line_t r;
		r = LN_OPEN;
		if (c.below_ra)
			r = LN_RA;                                          // R11
		else if (c.below_open)
			r = LN_RD;
		return r;                                               // R16
	endfunction : classify

	tcad_line_t  line_a;
	tcad_line_t  line_b;
	tcad_line_t  cls_a_q, cls_a_d;
	tcad_line_t  cls_b_q, cls_b_d;
	tcad_state_t st_q, st_d;
	logic [31:0] deb_q, deb_d;
	logic [31:0] drp_cnt_q, drp_cnt_d;
	logic        drp_src_q, drp_src_d;
	logic        fault_q, fault_d;
	logic        vbus_q, vbus_d;
	logic        vca_q, vca_d, vcb_q, vcb_d;
	logic        cable_q, cable_d;
	logic        wa_q, wa_d, wb_q, wb_d;
	logic        flip_q, flip_d;
	tcad_rp_t    rp_q, rp_d;
	tcad_rp_t    adv_q, adv_d;
	tcad_term_t  ta_q, ta_d, tb_q, tb_d;
	logic        as_source;
	logic        disc;

	assign line_a = classify(CMP_LINE_A);
	assign line_b = classify(CMP_LINE_B);
	assign as_source = (ROLE == ROLE_SOURCE) ||
		(ROLE == ROLE_DRP && drp_src_q && st_q == ST_NONE) ||
		(ROLE == ROLE_DRP && st_q != ST_NONE && st_q != ST_SNK_ATT);

	// Disconnect on a watched line; cable-only states use the Ra line only
	assign disc = (st_q == ST_CABLE_A) ? CMP_LINE_A.above_disc :  // R4
		(st_q == ST_CABLE_B) ? CMP_LINE_B.above_disc :            // R5
		((wa_q && CMP_LINE_A.above_disc) ||
		(wb_q && CMP_LINE_B.above_disc));

	always_comb begin
		cls_a_d   = line_a;
		cls_b_d   = line_b;
		st_d      = st_q;
		deb_d     = '0;
		drp_cnt_d = drp_cnt_q;
		drp_src_d = drp_src_q;
		fault_d   = fault_q | LINE_OVERVOLTAGE | SUPPLY_REVERSE_CURRENT;
		rp_d      = rp_q;
		adv_d     = adv_q;
		// Dual-role toggling while nothing attached
		if (ROLE == ROLE_DRP && st_q == ST_NONE && !DEAD_BATTERY) begin
			if (drp_cnt_q >= DRP_HALF_CYCLES - 1) begin
				drp_cnt_d = '0;
				drp_src_d = ~drp_src_q;                         // R13
			end else
				drp_cnt_d = drp_cnt_q + 32'h1;
		end else
			drp_cnt_d = '0;
		if (st_q == ST_NONE) begin
			if (as_source && !DEAD_BATTERY) begin
				case ({cls_a_q, cls_b_q})
				{LN_RD, LN_OPEN}: st_d = ST_SINK_A;             // R2
				{LN_OPEN, LN_RD}: st_d = ST_SINK_B;             // R3
				{LN_RA, LN_OPEN}: st_d = ST_CABLE_A;            // R4
				{LN_OPEN, LN_RA}: st_d = ST_CABLE_B;            // R5
				{LN_RA, LN_RD}:   st_d = ST_CBL_SINK_A;         // R6
				{LN_RD, LN_RA}:   st_d = ST_CBL_SINK_B;         // R7
				{LN_RD, LN_RD}:   st_d = ST_DEBUG_ACC;          // R8
				{LN_RA, LN_RA}:   st_d = ST_AUDIO_ACC;          // R8
				default:          st_d = ST_NONE;               // R1
				endcase
			end else if (VBUS_PRESENT)
				st_d = ST_SNK_ATT;                              // R12
		end else if (st_q == ST_SNK_ATT) begin
			if (!VBUS_PRESENT)
				st_d = ST_NONE;
			if (CMP_LINE_A.adv_high || CMP_LINE_B.adv_high)
				adv_d = RP_HIGH;                                // R12
			else if (CMP_LINE_A.adv_medium || CMP_LINE_B.adv_medium)
				adv_d = RP_MEDIUM;
			else
				adv_d = RP_DEFAULT;
		end else if (st_q == ST_CABLE_A && cls_b_q == LN_RD) begin
			st_d = ST_CBL_SINK_A;                               // R4
		end else if (st_q == ST_CABLE_B && cls_a_q == LN_RD) begin
			st_d = ST_CBL_SINK_B;                               // R5
		end else if (disc) begin
			if (deb_q >= DEBOUNCE_CYCLES - 1)
				st_d = ST_NONE;                                 // R10
			else
				deb_d = deb_q + 32'h1;                          // R10
		end
		if (st_d == ST_NONE || st_d == ST_SNK_ATT)
			rp_d = RP_DEFAULT;
		else if (VBUS_SWITCH_CLOSED)
			rp_d = RP_LEVEL_REQ;                                // R9
		else
			rp_d = RP_DEFAULT;                                  // R9
		if (st_d != ST_SNK_ATT)
			adv_d = RP_DEFAULT;
	end

	// Power, watch and termination outputs from next state
	always_comb begin
		vbus_d = 1'b0;
		vca_d  = 1'b0;
		vcb_d  = 1'b0;
		wa_d   = 1'b1;
		wb_d   = 1'b1;
		flip_d = 1'b0;
		case (st_d)
		ST_SINK_A:     wb_d = 1'b0;                             // R2
		ST_SINK_B: begin
			wa_d = 1'b0;                                        // R3
			flip_d = 1'b1;
		end
		ST_CBL_SINK_A: begin
			wa_d = 1'b0;                                        // R6
			vca_d = 1'b1;
			flip_d = 1'b1;
		end
		ST_CBL_SINK_B: begin
			wb_d = 1'b0;                                        // R7
			vcb_d = 1'b1;
		end
		ST_CABLE_B:    flip_d = 1'b1;
		ST_SNK_ATT:    flip_d = CMP_LINE_B.below_open;
		default:       flip_d = 1'b0;
		endcase
		vbus_d = (st_d == ST_SINK_A || st_d == ST_SINK_B ||
			st_d == ST_CBL_SINK_A || st_d == ST_CBL_SINK_B ||
			st_d == ST_DEBUG_ACC || st_d == ST_AUDIO_ACC) &&
			!fault_d;
		if (fault_d) begin
			vca_d = 1'b0;                                       // R15
			vcb_d = 1'b0;
		end
		cable_d = vca_d | vcb_d;                                // R15
		ta_d.pullup_lvl = rp_d;
		tb_d.pullup_lvl = rp_d;
		if (DEAD_BATTERY || ROLE == ROLE_SINK || st_d == ST_SNK_ATT ||
			(ROLE == ROLE_DRP && st_d == ST_NONE && !drp_src_d)) begin
			ta_d.pullup_en   = 1'b0;                            // R12 R14
			ta_d.pulldown_en = 1'b1;
		end else begin
			ta_d.pullup_en   = 1'b1;                            // R13
			ta_d.pulldown_en = 1'b0;
		end
		tb_d.pullup_en   = ta_d.pullup_en;
		tb_d.pulldown_en = ta_d.pulldown_en;
	end

	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			cls_a_q   <= LN_OPEN;
			cls_b_q   <= LN_OPEN;
			st_q      <= ST_NONE;
			deb_q     <= '0;
			drp_cnt_q <= '0;
			drp_src_q <= 1'b1;
			fault_q   <= 1'b0;
			rp_q      <= RP_DEFAULT;
			adv_q     <= RP_DEFAULT;
			vbus_q    <= 1'b0;
			vca_q     <= 1'b0;
			vcb_q     <= 1'b0;
			cable_q   <= 1'b0;
			wa_q      <= 1'b1;
			wb_q      <= 1'b1;
			flip_q    <= 1'b0;
			ta_q      <= '{1'b0, RP_DEFAULT, 1'b1};
			tb_q      <= '{1'b0, RP_DEFAULT, 1'b1};
		end else begin
			cls_a_q   <= cls_a_d;
			cls_b_q   <= cls_b_d;
			st_q      <= st_d;
			deb_q     <= deb_d;
			drp_cnt_q <= drp_cnt_d;
			drp_src_q <= drp_src_d;
			fault_q   <= fault_d;
			rp_q      <= rp_d;
			adv_q     <= adv_d;
			vbus_q    <= vbus_d;
			vca_q     <= vca_d;
			vcb_q     <= vcb_d;
			cable_q   <= cable_d;
			wa_q      <= wa_d;
			wb_q      <= wb_d;
			flip_q    <= flip_d;
			ta_q      <= ta_d;
			tb_q      <= tb_d;
		end
	end

	assign TERM_LINE_A     = ta_q;
	assign TERM_LINE_B     = tb_q;
	assign CONN_STATE      = st_q;
	assign VBUS_EN         = vbus_q;
	assign VCONN_A_EN      = vca_q;
	assign VCONN_B_EN      = vcb_q;
	assign WATCH_A         = wa_q;
	assign WATCH_B         = wb_q;
	assign FLIPPED         = flip_q;
	assign ADV_CURRENT     = adv_q;
	assign CABLE_SWITCH_EN = cable_q;                           // R15
	assign PD_TX_DISABLE   = fault_q;                           // R15
	assign FAULT           = fault_q;

endmodule : tcad_attach_detect

// ### dv/tcad_partner.sv
// Port partner model: presented terminations to comparator results
module tcad_partner
	import tcad_pkg::*;
(
	input  wire tcad_line_t pres_a,
	input  wire tcad_line_t pres_b,
	input  wire logic       src,
	input  wire tcad_rp_t   adv,
	input  wire tcad_term_t term_a,
	input  wire tcad_term_t term_b,
	output tcad_cmp_t       cmp_a,
	output tcad_cmp_t       cmp_b
);
	timeunit 1ns;
	timeprecision 100ps;
	// Without a pull-up the line sits low; a source partner shows its level
	function automatic tcad_cmp_t volt(tcad_line_t p, tcad_term_t t);
		logic pu;
		pu = t.pullup_en;
		return '{pu & p == LN_RA, pu & p != LN_OPEN, pu & p == LN_OPEN,
			src & !pu & adv != RP_DEFAULT, src & !pu & adv == RP_HIGH};
	endfunction : volt
	assign cmp_a = volt(pres_a, term_a);
	assign cmp_b = volt(pres_b, term_b);
endmodule : tcad_partner

// ### dv/tcad_assertions.sv
// Checker: port relations of the attach detector
module tcad_assertions
	import tcad_pkg::*;
#(
	parameter int DEBOUNCE_CYCLES = 8
) (
	input wire logic        MCLK,
	input wire logic        RESETN,
	input wire tcad_role_t  ROLE,
	input wire logic        VBUS_SWITCH_CLOSED,
	input wire logic        LINE_OVERVOLTAGE,
	input wire logic        SUPPLY_REVERSE_CURRENT,
	input wire tcad_cmp_t   CMP_LINE_A,
	input wire tcad_term_t  TERM_LINE_A,
	input wire tcad_term_t  TERM_LINE_B,
	input wire tcad_state_t CONN_STATE,
	input wire logic        VBUS_EN,
	input wire logic        VCONN_A_EN,
	input wire logic        WATCH_A,
	input wire logic        WATCH_B,
	input wire logic        CABLE_SWITCH_EN,
	input wire logic        PD_TX_DISABLE,
	input wire logic        FAULT
);
	timeunit 1ns;
	timeprecision 100ps;
	int unsigned hi_q;
	int unsigned hi_d;
	// Run length of line A above the disconnect threshold
	always_comb begin
		hi_d = CMP_LINE_A.above_disc ? hi_q + 1 : 0;
	end
	always_ff @(posedge MCLK or negedge RESETN) begin
		if (!RESETN) begin
			hi_q <= 0;
		end else begin
			hi_q <= hi_d;
		end
	end
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RESETN);
	a_idle_power_off: assert property (
		CONN_STATE == ST_NONE |-> !VBUS_EN && !VCONN_A_EN && WATCH_A && WATCH_B)
		else $error("idle state with power on or a line unwatched");
	a_sink_a_orient: assert property (
		CONN_STATE == ST_SINK_A && !FAULT |->
		VBUS_EN && !VCONN_A_EN && WATCH_A && !WATCH_B)
		else $error("line A sink outputs wrong");
	a_cable_no_power: assert property (
		CONN_STATE inside {ST_CABLE_A, ST_CABLE_B} |->
		!VBUS_EN && !CABLE_SWITCH_EN && WATCH_A && WATCH_B)
		else $error("cable-only state powers the port");
	a_cable_holds: assert property (
		CONN_STATE == ST_CABLE_A && !CMP_LINE_A.above_disc |=>
		CONN_STATE != ST_NONE)
		else $error("cable state left while its line stayed terminated");
	a_vconn_a_owner: assert property (
		VCONN_A_EN |-> CONN_STATE == ST_CBL_SINK_A && WATCH_B && !WATCH_A)
		else $error("line A supply outside its state");
	a_default_pullup: assert property (
		TERM_LINE_A.pullup_en && !$past(VBUS_SWITCH_CLOSED) |->
		TERM_LINE_A.pullup_lvl == RP_DEFAULT)
		else $error("raised pull-up before switch closed");
	a_detach_debounce: assert property (
		$past(CONN_STATE) == ST_SINK_A && CONN_STATE == ST_NONE && !FAULT |->
		hi_q >= DEBOUNCE_CYCLES)
		else $error("detach before debounce time");
	a_sink_terms: assert property (
		ROLE == ROLE_SINK && $past(ROLE) == ROLE_SINK |->
		TERM_LINE_A.pulldown_en && TERM_LINE_B.pulldown_en &&
		!TERM_LINE_A.pullup_en)
		else $error("sink role without pulldowns");
	a_fault_response: assert property (
		LINE_OVERVOLTAGE || SUPPLY_REVERSE_CURRENT |=>
		FAULT && PD_TX_DISABLE && !CABLE_SWITCH_EN && !VBUS_EN)
		else $error("fault not acted on next cycle");
	a_fault_sticky: assert property (
		FAULT |=> FAULT && PD_TX_DISABLE && !CABLE_SWITCH_EN)
		else $error("fault latch released");
endmodule : tcad_assertions

// ### dv/testbench.sv
// Testbench: scenario tasks for the attach detector
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import tcad_pkg::*;
	logic        mclk, rstn, dead, vbus_p, sw_cl, ovp, rcp, src;
	logic        vbus_en, va, vb, wa, wb, cable_sw, tx_dis, fault;
	logic        flip;
	tcad_role_t  role;
	tcad_rp_t    rp_req, adv, adv_cur;
	tcad_line_t  pres_a, pres_b;
	tcad_cmp_t   cmp_a, cmp_b;
	tcad_term_t  term_a, term_b;
	tcad_state_t st;
	int          mismatches, checks_done;
	tcad_attach_detect #(.DEBOUNCE_CYCLES(8), .DRP_HALF_CYCLES(16)) dut (
		.MCLK(mclk), .RESETN(rstn), .ROLE(role), .RP_LEVEL_REQ(rp_req),
		.DEAD_BATTERY(dead), .VBUS_PRESENT(vbus_p),
		.VBUS_SWITCH_CLOSED(sw_cl), .LINE_OVERVOLTAGE(ovp),
		.SUPPLY_REVERSE_CURRENT(rcp), .CMP_LINE_A(cmp_a), .CMP_LINE_B(cmp_b),
		.TERM_LINE_A(term_a), .TERM_LINE_B(term_b), .CONN_STATE(st),
		.VBUS_EN(vbus_en), .VCONN_A_EN(va), .VCONN_B_EN(vb), .WATCH_A(wa),
		.WATCH_B(wb), .FLIPPED(flip), .ADV_CURRENT(adv_cur),
		.CABLE_SWITCH_EN(cable_sw), .PD_TX_DISABLE(tx_dis), .FAULT(fault));
	tcad_partner peer (.pres_a(pres_a), .pres_b(pres_b), .src(src),
		.adv(adv), .term_a(term_a), .term_b(term_b), .cmp_a(cmp_a),
		.cmp_b(cmp_b));
	always #2 mclk = ~mclk;
	task automatic tick(int n);
		repeat (n) @(negedge mclk);
	endtask : tick
	task automatic cmp(string what, logic [4:0] exp, logic [4:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s exp %h got %h", what, exp, got);
		end
	endtask : cmp
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : tally_and_finish
	task automatic wait_st(tcad_state_t s, int lim);
		int n;
		n = 0;
		while (st !== s && n < lim) begin
			tick(1);
			n++;
		end
		cmp("state", {1'h0, s}, {1'h0, st});
		if (st !== s)
			tally_and_finish();
	endtask : wait_st
	task automatic attach(tcad_line_t a, tcad_line_t b, tcad_state_t s,
		logic [4:0] p);
		logic fl;
		fl = s inside {ST_SINK_B, ST_CBL_SINK_A, ST_CABLE_B};
		pres_a = a;
		pres_b = b;
		wait_st(s, 20);
		cmp("power and watch", p, {vbus_en, va, vb, wa, wb});
		cmp("orientation", {4'h0, fl}, {4'h0, flip});
		pres_a = LN_OPEN;
		pres_b = LN_OPEN;
		wait_st(ST_NONE, 40);
		cmp("idle outputs", 5'h03, {vbus_en, va, vb, wa, wb});
	endtask : attach
	task automatic s_table();
		attach(LN_RD, LN_OPEN, ST_SINK_A, 5'h12);
		attach(LN_OPEN, LN_RD, ST_SINK_B, 5'h11);
		attach(LN_RA, LN_OPEN, ST_CABLE_A, 5'h03);
		attach(LN_OPEN, LN_RA, ST_CABLE_B, 5'h03);
		attach(LN_RA, LN_RD, ST_CBL_SINK_A, 5'h19);
		attach(LN_RD, LN_RA, ST_CBL_SINK_B, 5'h16);
		attach(LN_RD, LN_RD, ST_DEBUG_ACC, 5'h13);
		attach(LN_RA, LN_RA, ST_AUDIO_ACC, 5'h13);
		pres_a = LN_RA;
		wait_st(ST_CABLE_A, 20);
		tick(20);
		cmp("cable holds", 5'(ST_CABLE_A), 5'(st));
		pres_b = LN_RD;
		wait_st(ST_CBL_SINK_A, 20);
	endtask : s_table
	task automatic s_level_debounce();
		int n;
		rp_req = RP_HIGH;
		pres_a = LN_OPEN;
		pres_b = LN_OPEN;
		wait_st(ST_NONE, 40);
		pres_a = LN_RD;
		wait_st(ST_SINK_A, 20);
		tick(3);
		cmp("level open switch", 5'(RP_DEFAULT), 5'(term_a.pullup_lvl));
		sw_cl = 1'h1;
		tick(3);
		cmp("level closed switch", 5'(RP_HIGH), 5'(term_a.pullup_lvl));
		pres_a = LN_OPEN;
		tick(6);
		pres_a = LN_RD;
		tick(4);
		cmp("gap keeps attach", 5'(ST_SINK_A), 5'(st));
		pres_a = LN_OPEN;
		n = 0;
		while (st !== ST_NONE && n < 40) begin
			tick(1);
			n++;
		end
		cmp("debounce length", 5'h01, 5'(n >= 8 && n <= 11));
		sw_cl = 1'h0;
		rp_req = RP_DEFAULT;
	endtask : s_level_debounce
	task automatic s_sink();
		role = ROLE_SINK;
		src = 1'h1;
		for (int i = 0; i < 3; i++) begin
			adv = tcad_rp_t'(i);
			vbus_p = 1'h1;
			wait_st(ST_SNK_ATT, 20);
			tick(3);
			cmp("advertised", 5'(i), 5'(adv_cur));
			cmp("pulldowns", 5'h03, {3'h0, term_a.pulldown_en, term_b.pulldown_en});
			vbus_p = 1'h0;
			wait_st(ST_NONE, 20);
		end
		src = 1'h0;
	endtask : s_sink
	task automatic s_drp();
		int n;
		logic last;
		role = ROLE_DRP;
		n = 0;
		last = term_a.pullup_en;
		for (int i = 0; i < 80; i++) begin
			tick(1);
			n += int'(term_a.pullup_en !== last);
			last = term_a.pullup_en;
		end
		cmp("role toggles", 5'h01, 5'(n >= 3 && n <= 6));
		role = ROLE_SOURCE;
		tick(4);
	endtask : s_drp
	task automatic s_dead();
		dead = 1'h1;
		pres_a = LN_RD;
		tick(10);
		cmp("dead battery", 5'h01, {3'h0, vbus_en, term_a.pulldown_en});
		dead = 1'h0;
		wait_st(ST_SINK_A, 30);
	endtask : s_dead
	task automatic reset_dut();
		rstn = 1'h0;
		tick(8);
		rstn = 1'h1;
	endtask : reset_dut
	task automatic s_fault();
		for (int k = 0; k < 2; k++) begin
			pres_a = LN_OPEN;
			pres_b = LN_OPEN;
			wait_st(ST_NONE, 40);
			pres_a = LN_RA;
			pres_b = LN_RD;
			wait_st(ST_CBL_SINK_A, 40);
			cmp("cable switch", 5'h01, {4'h0, cable_sw});
			ovp = (k == 0);
			rcp = (k == 1);
			tick(1);
			ovp = 1'h0;
			rcp = 1'h0;
			cmp("fault act", 5'h0C, {1'h0, fault, tx_dis, cable_sw, vbus_en});
			tick(5);
			cmp("fault held", 5'h0C, {1'h0, fault, tx_dis, cable_sw, vbus_en});
			pres_a = LN_OPEN;
			pres_b = LN_OPEN;
			reset_dut();
			wait_st(ST_NONE, 5);
			cmp("fault cleared", 5'h00, {3'h0, fault, tx_dis});
		end
	endtask : s_fault
	initial begin
		mclk = 1'h0;
		rstn = 1'h0;
		role = ROLE_SOURCE;
		rp_req = RP_DEFAULT;
		adv = RP_DEFAULT;
		{dead, vbus_p, sw_cl, ovp, rcp, src} = 6'h00;
		pres_a = LN_OPEN;
		pres_b = LN_OPEN;
		mismatches = 0;
		checks_done = 0;
		reset_dut();
		s_table();
		s_level_debounce();
		s_sink();
		s_drp();
		s_dead();
		s_fault();
		tally_and_finish();
	end
endmodule : testbench
bind tcad_attach_detect tcad_assertions #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES))
	chk (.MCLK(MCLK), .RESETN(RESETN), .ROLE(ROLE),
	.VBUS_SWITCH_CLOSED(VBUS_SWITCH_CLOSED), .LINE_OVERVOLTAGE(LINE_OVERVOLTAGE),
	.SUPPLY_REVERSE_CURRENT(SUPPLY_REVERSE_CURRENT), .CMP_LINE_A(CMP_LINE_A),
	.TERM_LINE_A(TERM_LINE_A), .TERM_LINE_B(TERM_LINE_B),
	.CONN_STATE(CONN_STATE), .VBUS_EN(VBUS_EN), .VCONN_A_EN(VCONN_A_EN),
	.WATCH_A(WATCH_A), .WATCH_B(WATCH_B), .CABLE_SWITCH_EN(CABLE_SWITCH_EN),
	.PD_TX_DISABLE(PD_TX_DISABLE), .FAULT(FAULT));
